// [core/pod_params.svh]
// constants for the pwm output disable unit
// assumes inclusion by bare name from the core files
`ifndef POD_PARAMS_SVH
`define POD_PARAMS_SVH
`define POD_GROUPS 4
`define POD_OFF_GRP_A 12'h000
`define POD_OFF_GRP_B 12'h004
`define POD_OFF_GRP_C 12'h008
`define POD_OFF_GRP_D 12'h00c
`define POD_OFF_CTRL 12'h010
`define POD_OFF_STAT 12'h014
`define POD_BIT_PORT_INPUT_DETECT_FLAG 0
`define POD_BIT_TIMER_COMPARATOR_REQUEST_FLAG 1
`define POD_BIT_OSTF 2
`define POD_BIT_SSF 3
`define POD_BIT_PIDE 4
`define POD_BIT_IOCE 5
`define POD_BIT_OSTE 6
`define POD_BIT_SWREQ 8
`define POD_FLAGS_MASK 4'hf
`define POD_RST_WORD 32'h0000_0000
`define POD_RST_CTRL 32'h0000_0000
`define POD_CTRL_GSEL_LO 0
`define POD_CTRL_DVA 2
`define POD_CTRL_DVB 3
`define POD_CTRL_OEA 4
`define POD_CTRL_OEB 5
`endif

// [core/pod_pkg.sv]
// types shared by the pwm output disable unit
// assumes pod_params.svh is on the include path
package pod_pkg;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pod_apb_req_t;
  typedef struct packed {
    logic [3:0] flags;
    logic       pinEn;
    logic       reqEn;
    logic       oscEn;
  } pod_group_t;
  typedef enum logic [1:0] {
    POD_GRP_A = 2'b00,
    POD_GRP_B = 2'b01,
    POD_GRP_C = 2'b10,
    POD_GRP_D = 2'b11
  } pod_gsel_t;
endpackage

// [core/pod_group.sv]
// one output-disable group: trip edge detect and latched cause flags
// assumes trip input already synchronised to sys_clk
`timescale 1ns/1ps
`default_nettype none
`include "pod_params.svh"
module pod_group (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic tripSync,
  input wire logic timerReq,
  input wire logic oscStop,
  input wire logic swStop,
  input wire logic wrEn,
  input wire logic [31:0] wrData,
  output var pod_pkg::pod_group_t state,
  output logic event_pulse
);
  import pod_pkg::*;
  logic tripPrev;
  logic [3:0] setVec;
  logic [3:0] clrVec;

  // previous trip level for rising edge detect
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tripPrev <= 1'b0;
    end else begin
      tripPrev <= tripSync;
    end
  end

  // cause detection per flag
  always_comb begin
    setVec = 4'h0;
    setVec[`POD_BIT_PORT_INPUT_DETECT_FLAG] = state.pinEn & tripSync & ~tripPrev;
    setVec[`POD_BIT_TIMER_COMPARATOR_REQUEST_FLAG] = state.reqEn & timerReq;
    setVec[`POD_BIT_OSTF] = state.oscEn & oscStop;
    setVec[`POD_BIT_SSF] = swStop;
    // writing zero to a flag clears it; ones leave it alone
    clrVec = wrEn ? ~wrData[3:0] : 4'h0;
  end

  // flags latch until cleared; set wins over a same-cycle clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= '0;
      event_pulse <= 1'b0;
    end else begin
      state.flags <= setVec | (state.flags & ~clrVec); // [R5] [R10] [R6]
      event_pulse <= |(setVec & ~state.flags); // [R7]
      if (wrEn) begin
        state.pinEn <= wrData[`POD_BIT_PIDE];
        state.reqEn <= wrData[`POD_BIT_IOCE];
        state.oscEn <= wrData[`POD_BIT_OSTE];
      end
    end
  end

  a_flag_holds: assert property (@(posedge sys_clk) disable iff (rst) // [R10]
    $past(state.flags[`POD_BIT_PORT_INPUT_DETECT_FLAG]) && !$past(wrEn) |->
      state.flags[`POD_BIT_PORT_INPUT_DETECT_FLAG])
    else $error("trip flag dropped without a clear");
  a_edge_sets: assert property (@(posedge sys_clk) disable iff (rst) // [R2]
    state.pinEn && tripSync && !tripPrev |=> state.flags[`POD_BIT_PORT_INPUT_DETECT_FLAG])
    else $error("trip edge did not set flag");
  a_event_flag: assert property (@(posedge sys_clk) disable iff (rst) // [R7]
    event_pulse |-> state.flags != 4'h0)
    else $error("event pulse with no flag");
endmodule
`default_nettype wire

// [core/pod_unit.sv]
// pwm output disable unit, apb slave with four groups
// assumes apb master on sys_clk; trip pins asynchronous to it
// What this block does
// R1: four causes force timer outputs disabled
// R2: trip rising edge disables outputs, raises interrupt
// R3: oscillator stop disables outputs, raises nmi
// R4: four groups, own trip inputs, selectable
// R5: four cause flags per group register
// R6: clearing all flags releases the outputs
// R7: each group has its own interrupt
// R8: timer channel follows only selected group
// R9: disabled pin level follows per-pin value
// R10: flags latch until software clears them
`timescale 1ns/1ps
`default_nettype none
`include "pod_params.svh"
module pod_unit #(
  parameter int GROUPS = `POD_GROUPS
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire pod_pkg::pod_apb_req_t apbReq,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] external_trip_input,
  input wire logic [3:0] timer_comparator_req,
  input wire logic osc_stop_detect,
  input wire logic pwm_out_a,
  input wire logic pwm_out_b,
  output logic timer0_output_a,
  output logic timer0_output_a_oe,
  output logic timer0_output_b,
  output logic timer0_output_b_oe,
  output logic [3:0] group_irq,
  output logic osc_nmi
);
  import pod_pkg::*;
  // the decode and the read mux are written for exactly four groups
  if (GROUPS != `POD_GROUPS) begin : gGroupCheck
    $error("pod_unit serves four groups only");
  end

  logic [3:0] tripMeta;
  logic [3:0] tripSync;
  logic oscMeta;
  logic oscSync;
  logic [3:0] wrGrp;
  logic [3:0] swStop;
  logic [3:0] evt;
  pod_group_t grp [4];
  logic [31:0] ctrl;
  logic access;
  logic [31:0] next_rdata;
  logic next_err;
  logic disableNow;
  pod_gsel_t gsel;

  // two-flop synchronisers; first stage feeds only the second
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tripMeta <= 4'h0;
      tripSync <= 4'h0;
      oscMeta <= 1'b0;
      oscSync <= 1'b0;
    end else begin
      tripMeta <= external_trip_input;
      tripSync <= tripMeta;
      oscMeta <= osc_stop_detect;
      oscSync <= oscMeta;
    end
  end

  // access phase; answer registered, in the second access cycle, one wait
  assign access = apbReq.psel & apbReq.penable & ~pready;

  // decode group register writes and software stop requests
  always_comb begin
    wrGrp = 4'h0;
    swStop = 4'h0;
    if (access && apbReq.pwrite) begin
      unique case (apbReq.paddr)
        `POD_OFF_GRP_A: wrGrp[0] = 1'b1;
        `POD_OFF_GRP_B: wrGrp[1] = 1'b1;
        `POD_OFF_GRP_C: wrGrp[2] = 1'b1;
        `POD_OFF_GRP_D: wrGrp[3] = 1'b1;
        default: wrGrp = 4'h0;
      endcase
    end
    for (int i = 0; i < 4; i++) begin
      swStop[i] = wrGrp[i] & apbReq.pwdata[`POD_BIT_SWREQ]; // [R1]
    end
  end

  // one instance per group, each with its own trip pin
  for (genvar g = 0; g < 4; g++) begin : gGrp
    pod_group uGrp (
      .sys_clk(sys_clk),
      .rst(rst),
      .tripSync(tripSync[g]), // [R4]
      .timerReq(timer_comparator_req[g]),
      .oscStop(oscSync), // [R3]
      .swStop(swStop[g]),
      .wrEn(wrGrp[g]),
      .wrData(apbReq.pwdata),
      .state(grp[g]),
      .event_pulse(evt[g])
    );
  end

  // control register: group select, disable levels, idle enables
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl <= `POD_RST_CTRL;
    end else if (access && apbReq.pwrite &&
                 apbReq.paddr == `POD_OFF_CTRL) begin
      ctrl <= {26'h0, apbReq.pwdata[5:0]};
    end
  end

  assign gsel = pod_gsel_t'(ctrl[`POD_CTRL_GSEL_LO +: 2]);
  // only the selected group disables channel 0
  assign disableNow = |grp[gsel].flags; // [R8] [R1] [R6]

  // read mux
  always_comb begin
    next_rdata = `POD_RST_WORD;
    next_err = 1'b0;
    unique case (apbReq.paddr)
      `POD_OFF_GRP_A, `POD_OFF_GRP_B, `POD_OFF_GRP_C, `POD_OFF_GRP_D: begin
        next_rdata[3:0] = grp[apbReq.paddr[3:2]].flags; // [R5]
        next_rdata[`POD_BIT_PIDE] = grp[apbReq.paddr[3:2]].pinEn;
        next_rdata[`POD_BIT_IOCE] = grp[apbReq.paddr[3:2]].reqEn;
        next_rdata[`POD_BIT_OSTE] = grp[apbReq.paddr[3:2]].oscEn;
      end
      `POD_OFF_CTRL: next_rdata = ctrl;
      `POD_OFF_STAT: next_rdata = {30'h0, oscSync, disableNow};
      default: next_err = 1'b1;
    endcase
  end

  // apb answer registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= `POD_RST_WORD;
      pslverr <= 1'b0;
    end else begin
      pready <= access;
      pslverr <= access & next_err;
      if (access && !apbReq.pwrite) begin
        prdata <= next_rdata;
      end
    end
  end

  // outputs: when disabled, enables from OEA/OEB and levels from the disable values
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      timer0_output_a <= 1'b0;
      timer0_output_b <= 1'b0;
      timer0_output_a_oe <= 1'b0;
      timer0_output_b_oe <= 1'b0;
    end else if (disableNow) begin
      timer0_output_a <= ctrl[`POD_CTRL_DVA]; // [R9]
      timer0_output_b <= ctrl[`POD_CTRL_DVB]; // [R9]
      timer0_output_a_oe <= ctrl[`POD_CTRL_OEA]; // [R2] [R3]
      timer0_output_b_oe <= ctrl[`POD_CTRL_OEB];
    end else begin
      timer0_output_a <= pwm_out_a;
      timer0_output_b <= pwm_out_b;
      timer0_output_a_oe <= 1'b1;
      timer0_output_b_oe <= 1'b1;
    end
  end

  // per-group interrupt pulse and oscillator nmi level
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      group_irq <= 4'h0;
      osc_nmi <= 1'b0;
    end else begin
      group_irq <= evt; // [R7] [R2]
      osc_nmi <= oscSync; // [R3]
    end
  end

  // channel checks; irq and nmi flops lag their sources by one edge
  a_disable_hiz: assert property (@(posedge sys_clk) disable iff (rst) // [R1]
    disableNow && !ctrl[`POD_CTRL_OEA] |=> !timer0_output_a_oe)
    else $error("output a not released to high impedance");
  // sampled rst keeps the release edge itself out of this check
  a_release_out: assert property (@(posedge sys_clk) disable iff (rst) // [R6]
    !disableNow && !rst |=> timer0_output_a_oe && timer0_output_b_oe)
    else $error("outputs not released after flags cleared");
  a_nmi_follow: assert property (@(posedge sys_clk) disable iff (rst) // [R3]
    oscSync |=> osc_nmi)
    else $error("nmi missing on oscillator stop");
  a_irq_event: assert property (@(posedge sys_clk) disable iff (rst) // [R7]
    |(grp[0].flags & ~$past(grp[0].flags)) |=> group_irq[0])
    else $error("group interrupt missing");
  a_disval_a: assert property (@(posedge sys_clk) disable iff (rst) // [R9]
    disableNow |=> timer0_output_a == $past(ctrl[`POD_CTRL_DVA]))
    else $error("disable value wrong on output a");
  // group b's flag must come from group b's own pin
  a_group_pin: assert property (@(posedge sys_clk) disable iff (rst) // [R4]
    $rose(tripSync[1]) && grp[1].pinEn |=> grp[1].flags[`POD_BIT_PORT_INPUT_DETECT_FLAG])
    else $error("trip pin b did not reach group b");
  // trip on group a while selected: interrupt and disable on one edge
  sequence sTripRise;
    $rose(tripSync[0]) && grp[0].pinEn && !grp[0].flags[`POD_BIT_PORT_INPUT_DETECT_FLAG];
  endsequence
  sequence sChanOff;
    group_irq[0] && timer0_output_b_oe == $past(ctrl[`POD_CTRL_OEB]);
  endsequence
  a_trip_off: assert property (@(posedge sys_clk) disable iff (rst) // [R2]
    sTripRise ##1 (gsel == POD_GRP_A) |=> sChanOff)
    else $error("trip edge did not disable channel with interrupt");
endmodule
`default_nettype wire

// [verification/pod_far_model.sv]
// far side: timer waveform and trip sources on bench command
// assumes commands change just after rising edges of sys_clk
`timescale 1ns/1ps
`default_nettype none
module pod_far_model (
  input wire logic sys_clk,
  input wire logic [3:0] tripCmd,
  input wire logic [3:0] reqCmd,
  input wire logic oscCmd,
  output logic [3:0] tripPin,
  output logic [3:0] timerReq,
  output logic oscStop,
  output logic pwmA,
  output logic pwmB
);
  // waveform levels differ from the disable values, so a swap shows
  assign pwmA = 1'b0;
  assign pwmB = 1'b1;
  // sources follow commands one edge later; unknown only before the
  // first edge, which falls inside the bench's reset
  always @(posedge sys_clk) begin
    tripPin <= tripCmd;
    timerReq <= reqCmd;
    oscStop <= oscCmd;
  end
endmodule
`default_nettype wire

// [verification/pwm_output_disable_unit_tb_top.sv]
// self-checking bench for the pwm output disable unit
// assumes pod_far_model drives the timer side; apb master here
`timescale 1ns/1ps
`default_nettype none
module pwm_output_disable_unit_tb_top;
  import pod_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  pod_apb_req_t req = '0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, oeA, oeB, outA, outB, nmi;
  logic pwmA, pwmB, osc, seen;
  logic oscCmd = 1'b0;
  logic [3:0] trip, treq, irq, pins;
  logic [3:0] tripCmd = 4'h0;
  logic [3:0] reqCmd = 4'h0;
  int badCount = 0;
  int samplesChecked = 0;
  int cyc = 0;
  int g;
  // pin view: enables first, then levels
  assign pins = {oeA, oeB, outA, outB};
  always #10 sys_clk = ~sys_clk;
  // timer side and trip sources
  pod_far_model far (.sys_clk(sys_clk), .tripCmd(tripCmd),
    .reqCmd(reqCmd), .oscCmd(oscCmd), .tripPin(trip),
    .timerReq(treq), .oscStop(osc), .pwmA(pwmA), .pwmB(pwmB));
  pod_unit #(.GROUPS(4)) uut (.sys_clk(sys_clk), .rst(rst),
    .apbReq(req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_trip_input(trip),
    .timer_comparator_req(treq), .osc_stop_detect(osc),
    .pwm_out_a(pwmA), .pwm_out_b(pwmB), .timer0_output_a(outA),
    .timer0_output_a_oe(oeA), .timer0_output_b(outB),
    .timer0_output_b_oe(oeB), .group_irq(irq), .osc_nmi(nmi));
  task automatic testDone();
    $display("checked %0d, mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      badCount++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer; waits for pready, bounded by the bench timeout
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    req <= '0;
    @(posedge sys_clk);
  endtask
  task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(33'(rd), 33'(exp));
  endtask
  // stops on the group's interrupt or on outputs going disabled
  task automatic wt(input int i);
    int k;
    seen = 1'b0;
    for (k = 0; k < 12 && !seen && oeB !== 1'b0; k++) begin
      @(posedge sys_clk);
      if (irq[i] === 1'b1) seen = 1'b1;
    end
  endtask
  // a hang ends the run as a mismatch
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      badCount++;
      testDone();
    end
  end
  // main sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    for (g = 0; g < 6; g++) rdChk(12'(4 * g), 32'h0);
    apb(1'b0, 12'h018, 32'h0);
    chk({er, rd}, 33'h1_0000_0000);
    chk(33'(pins), 33'hd);
    apb(1'b1, 12'h010, 32'h14);
    apb(1'b1, 12'h000, 32'h70);
    // each cause in turn; flags must outlive the cause
    for (g = 0; g < 4; g++) begin
      case (g)
        0: tripCmd <= 4'h1;
        1: reqCmd <= 4'h1;
        2: oscCmd <= 1'b1;
        default: apb(1'b1, 12'h000, 32'h170);
      endcase
      wt(0);
      if (g < 3) chk(33'(seen), 33'h1);
      if (g == 2) chk(33'(nmi), 33'h1);
      tripCmd <= 4'h0;
      reqCmd <= 4'h0;
      oscCmd <= 1'b0;
      repeat (6) @(posedge sys_clk);
      chk(33'(pins), 33'ha);
      rdChk(12'h000, 32'h70 | (32'h1 << g));
      rdChk(12'h014, 32'h1);
      apb(1'b1, 12'h000, 32'h70);
      repeat (2) @(posedge sys_clk);
      chk(33'(pins), 33'hd);
    end
    // unselected groups interrupt but leave the channel alone
    for (g = 1; g < 4; g++) begin
      apb(1'b1, 12'(4 * g), 32'h10);
      tripCmd <= 4'(1 << g);
      wt(g);
      chk(33'(seen), 33'h1);
      chk(33'(pins), 33'hd);
      tripCmd <= 4'h0;
      rdChk(12'(4 * g), 32'h11);
    end
    apb(1'b1, 12'h010, 32'h17);
    repeat (2) @(posedge sys_clk);
    chk(33'(pins), 33'ha);
    for (g = 1; g < 4; g++) apb(1'b1, 12'(4 * g), 32'h10);
    repeat (2) @(posedge sys_clk);
    chk(33'(pins), 33'hd);
    testDone();
  end
endmodule
`default_nettype wire
